// file: common/iis_pkg.sv
package iis_pkg;
   // ----------------------------------------
   // widths and sizes
   // ----------------------------------------
   localparam int IIS_W = 16;
   localparam int IIS_NLINES = 4;
   localparam int IIS_LINE_W = 2;
   // ----------------------------------------
   // reset values and fixed locations
   // ----------------------------------------
   localparam logic [15:0] IIS_RESET_PC = 16'h0000;
   localparam logic [15:0] IIS_INT_BASE = 16'h0020;
   // ----------------------------------------
   // instruction word layout
   // ----------------------------------------
   localparam int IIS_OP_HI = 15;
   localparam int IIS_OP_LO = 12;
   localparam int IIS_IND_BIT = 11;
   localparam int IIS_REL_BIT = 10;
   localparam int IIS_DISP_HI = 9;
   localparam int IIS_SUB_HI = 3;
   localparam int IIS_AUTO_OUT_BIT = 10;
   localparam int IIS_AUTO_BYTE_BIT = 11;
   // ----------------------------------------
   // opcodes and sub-operations
   // ----------------------------------------
   localparam logic [3:0] OP_MISC = 4'h0;
   localparam logic [3:0] OP_LDA = 4'h1;
   localparam logic [3:0] OP_ADD = 4'h2;
   localparam logic [3:0] OP_STA = 4'h3;
   localparam logic [3:0] OP_JMP = 4'h4;
   localparam logic [3:0] OP_JST = 4'h5;
   localparam logic [3:0] OP_INCR_SKIP = 4'h6;
   localparam logic [3:0] OP_LDX = 4'h7;
   localparam logic [3:0] OP_AUTO = 4'h8;
   localparam logic [3:0] SUB_INTERRUPTS_ON_OP = 4'h1;
   localparam logic [3:0] SUB_INTERRUPTS_OFF_OP = 4'h2;
   // ----------------------------------------
   // sequencer states and state record
   // ----------------------------------------
   typedef enum logic [9:0] {
      ST_FETCH = 10'h001, ST_IND = 10'h002, ST_OPER = 10'h004, ST_WRITE = 10'h008,
      ST_ACNT = 10'h010, ST_AADR = 10'h020, ST_AXFER = 10'h040, ST_AWCNT = 10'h080,
      ST_AWADR = 10'h100, ST_SPARE = 10'h200
   } iis_state_t;
   typedef struct packed {
      iis_state_t st;
      logic [15:0] pc;
      logic [15:0] ir;
      logic [15:0] ia;
      logic [15:0] ea;
      logic [15:0] cnt;
      logic [15:0] aadr;
      logic [15:0] acc;
      logic [15:0] idx;
      logic overflow_indicator;
      logic ien;
      logic int_cyc;
      logic [IIS_LINE_W-1:0] int_line;
      logic [IIS_NLINES-1:0] sync1;
      logic [IIS_NLINES-1:0] sync2;
      logic [IIS_NLINES-1:0] ack;
      logic [IIS_NLINES-1:0] echo;
      logic mem_req;
      logic mem_we;
      logic [15:0] mem_addr;
      logic [15:0] mem_wdata;
      logic io_wr;
      logic io_rd;
      logic io_byte;
      logic [15:0] io_wdata;
   } iis_seq_t;
endpackage

// file: rtl/iis_prio.sv
`timescale 1ns/1ps
module iis_prio
   import iis_pkg::*;
#(
   parameter int NLINES = IIS_NLINES,
   parameter int LINE_W = IIS_LINE_W
) (
   input wire logic [NLINES-1:0] pend,
   input wire logic [15:0] base,
   output logic any,
   output logic [LINE_W-1:0] line,
   output logic [15:0] loc
);
   // ----------------------------------------
   // fixed priority: lowest line number wins
   // ----------------------------------------
   always_comb begin
      any = 1'b0;
      line = '0;
      for (int i = NLINES - 1; i >= 0; i--) begin
         if (pend[i]) begin
            any = 1'b1;
            line = LINE_W'(i);
         end
      end
      // each line owns one fixed location at or above the base
      loc = base + {{(16 - LINE_W){1'b0}}, line};
   end
endmodule

// file: rtl/iis_seq.sv
`timescale 1ns/1ps
module iis_seq
   import iis_pkg::*;
#(
   parameter logic [15:0] INT_BASE = IIS_INT_BASE
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [IIS_NLINES-1:0] irq_req,
   output logic [IIS_NLINES-1:0] irq_ack,
   output logic [IIS_NLINES-1:0] irq_echo,
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   input wire logic [15:0] io_rd_data,
   output logic io_rd,
   output logic io_wr,
   output logic io_byte,
   output logic [15:0] io_wr_data,
   output logic [15:0] pc,
   output logic [15:0] acc,
   output logic [15:0] idx,
   output logic overflow_indicator,
   output logic int_enabled
);
   iis_seq_t s, n;
   logic pend_any;
   logic [IIS_LINE_W-1:0] pend_line;
   logic [15:0] pend_loc;

   // --------------------------------------------
   // priority pick among synchronised requests
   // --------------------------------------------
   iis_prio #(.NLINES(IIS_NLINES), .LINE_W(IIS_LINE_W)) u_prio (
      .pend(s.sync2),
      .base(INT_BASE),
      .any(pend_any),
      .line(pend_line),
      .loc(pend_loc)
   );

   // --------------------------------------------
   // next-state logic
   // --------------------------------------------
   always_comb begin
      logic [15:0] instr;
      logic [3:0] op;
      logic [15:0] ea_v;
      logic dispatch;
      logic fin;
      logic on_now;
      logic guard_now;
      logic rec;
      logic [16:0] sum;
      n = s;
      instr = (s.st == ST_FETCH) ? mem_rdata : s.ir;
      op = instr[IIS_OP_HI:IIS_OP_LO];
      ea_v = s.ea;
      dispatch = 1'b0;
      fin = 1'b0;
      on_now = 1'b0;
      guard_now = 1'b0;
      rec = 1'b0;
      sum = '0;
      n.sync1 = irq_req;
      n.sync2 = s.sync1;
      n.ack = '0;
      n.echo = '0;
      n.io_wr = 1'b0;
      n.io_rd = 1'b0;
      case (s.st)
         ST_FETCH: begin
            if (mem_ack) begin
               n.ir = mem_rdata;
               // the interrupt instruction's fetch never advances the counter
               if (!s.int_cyc) begin
                  n.pc = s.pc + 16'h0001;
               end
               // relative base is the instruction's own address
               if (mem_rdata[IIS_REL_BIT]) begin
                  ea_v = s.ia + {{6{mem_rdata[IIS_DISP_HI]}}, mem_rdata[IIS_DISP_HI:0]};
               end else begin
                  ea_v = {6'h00, mem_rdata[IIS_DISP_HI:0]};
               end
               if (op == OP_MISC) begin
                  if (mem_rdata[IIS_SUB_HI:0] == SUB_INTERRUPTS_ON_OP) begin
                     n.ien = 1'b1;
                     on_now = 1'b1;
                  end else if (mem_rdata[IIS_SUB_HI:0] == SUB_INTERRUPTS_OFF_OP) begin
                     n.ien = 1'b0;
                  end
                  fin = 1'b1;
               end else if (op == OP_AUTO) begin
                  n.ea = {6'h00, mem_rdata[IIS_DISP_HI:0]};
                  n.io_byte = mem_rdata[IIS_AUTO_BYTE_BIT];
                  n.st = ST_ACNT;
                  n.mem_we = 1'b0;
                  n.mem_addr = {6'h00, mem_rdata[IIS_DISP_HI:0]};
               end else if (mem_rdata[IIS_IND_BIT]) begin
                  n.st = ST_IND;
                  n.mem_we = 1'b0;
                  n.mem_addr = ea_v;
               end else begin
                  dispatch = 1'b1;
               end
            end
         end
         ST_IND: begin
            if (mem_ack) begin
               ea_v = mem_rdata;
               dispatch = 1'b1;
            end
         end
         ST_OPER: begin
            if (mem_ack) begin
               fin = 1'b1;
               case (op)
                  OP_LDA: n.acc = mem_rdata;
                  OP_LDX: n.idx = mem_rdata;
                  OP_ADD: begin
                     sum = {1'b0, s.acc} + {1'b0, mem_rdata};
                     n.acc = sum[15:0];
                     n.overflow_indicator = (s.acc[15] == mem_rdata[15]) &&
                        (sum[15] != s.acc[15]);
                  end
                  OP_INCR_SKIP: begin
                     fin = 1'b0;
                     n.st = ST_WRITE;
                     n.mem_we = 1'b1;
                     n.mem_wdata = mem_rdata + 16'h0001;
                  end
                  default: fin = 1'b1;
               endcase
            end
         end
         ST_WRITE: begin
            if (mem_ack) begin
               fin = 1'b1;
               if (op == OP_INCR_SKIP && s.mem_wdata == 16'h0000) begin
                  if (s.int_cyc) begin
                     n.echo[s.int_line] = 1'b1;
                  end else begin
                     n.pc = s.pc + 16'h0001;
                  end
               end
               if (op == OP_JST) begin
                  n.pc = s.ea + 16'h0001;
                  if (s.int_cyc) begin
                     n.ien = 1'b0;
                  end
               end
            end
         end
         ST_ACNT: begin
            if (mem_ack) begin
               n.cnt = mem_rdata;
               n.st = ST_AADR;
               n.mem_addr = s.ea + 16'h0001;
            end
         end
         ST_AADR: begin
            if (mem_ack) begin
               n.aadr = mem_rdata;
               n.st = ST_AXFER;
               n.mem_addr = mem_rdata;
               // input direction: take the interface's word and store it
               if (!s.ir[IIS_AUTO_OUT_BIT]) begin
                  n.io_rd = 1'b1;
                  n.mem_we = 1'b1;
                  n.mem_wdata = s.io_byte ? {8'h00, io_rd_data[7:0]} : io_rd_data;
               end
            end
         end
         ST_AXFER: begin
            if (mem_ack) begin
               if (s.ir[IIS_AUTO_OUT_BIT]) begin
                  n.io_wr = 1'b1;
                  n.io_wdata = s.io_byte ? {8'h00, mem_rdata[7:0]} : mem_rdata;
               end
               // descriptor write-back only; accumulator and counter untouched
               n.st = ST_AWCNT;
               n.mem_we = 1'b1;
               n.mem_addr = s.ea;
               n.mem_wdata = s.cnt + 16'h0001;
            end
         end
         ST_AWCNT: begin
            if (mem_ack) begin
               n.st = ST_AWADR;
               n.mem_addr = s.ea + 16'h0001;
               n.mem_wdata = s.aadr + 16'h0001;
            end
         end
         ST_AWADR: begin
            if (mem_ack) begin
               fin = 1'b1;
               // counted block finished: tell the interface
               if (s.cnt + 16'h0001 == 16'h0000) begin
                  n.echo[s.int_line] = 1'b1;
               end
            end
         end
         default: begin
            fin = 1'b1;
         end
      endcase
      // operand stage for direct or resolved indirect addresses
      if (dispatch) begin
         n.ea = ea_v;
         n.mem_addr = ea_v;
         case (op)
            OP_JMP: begin
               n.pc = ea_v;
               fin = 1'b1;
            end
            OP_JST: begin
               n.st = ST_WRITE;
               n.mem_we = 1'b1;
               n.mem_wdata = n.pc;
            end
            OP_STA: begin
               n.st = ST_WRITE;
               n.mem_we = 1'b1;
               n.mem_wdata = s.acc;
            end
            default: begin
               n.st = ST_OPER;
               n.mem_we = 1'b0;
            end
         endcase
      end
      // instruction boundary: the only place a request is recognised
      if (fin) begin
         guard_now = s.int_cyc;
         rec = n.ien && !on_now && !guard_now && pend_any;
         n.st = ST_FETCH;
         n.mem_req = 1'b1;
         n.mem_we = 1'b0;
         if (rec) begin
            n.int_cyc = 1'b1;
            n.int_line = pend_line;
            n.ack[pend_line] = 1'b1;
            n.ia = pend_loc;
            n.mem_addr = pend_loc;
         end else begin
            n.int_cyc = 1'b0;
            n.ia = n.pc;
            n.mem_addr = n.pc;
         end
      end
   end

   // --------------------------------------------
   // state register; reset starts a fetch at once
   // --------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.st <= ST_FETCH;
         s.pc <= IIS_RESET_PC;
         s.ia <= IIS_RESET_PC;
         s.mem_addr <= IIS_RESET_PC;
         s.mem_req <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign irq_ack = s.ack;
   assign irq_echo = s.echo;
   assign mem_req = s.mem_req;
   assign mem_we = s.mem_we;
   assign mem_addr = s.mem_addr;
   assign mem_wdata = s.mem_wdata;
   assign io_rd = s.io_rd;
   assign io_wr = s.io_wr;
   assign io_byte = s.io_byte;
   assign io_wr_data = s.io_wdata;
   assign pc = s.pc;
   assign acc = s.acc;
   assign idx = s.idx;
   assign overflow_indicator = s.overflow_indicator;
   assign int_enabled = s.ien;

   // --------------------------------------------
   // checks
   // --------------------------------------------
   logic incr_zero_wr;
   logic jst_wr;
   assign incr_zero_wr = s.st == ST_WRITE && mem_ack && s.ir[15:12] == OP_INCR_SKIP &&
      s.mem_wdata == 16'h0000;
   assign jst_wr = s.st == ST_WRITE && mem_ack && s.ir[15:12] == OP_JST;

   property p_incr_noskip;
      @(posedge mclk) disable iff (!arst_n) incr_zero_wr && s.int_cyc |=> $stable(s.pc);
   endproperty
   a_incr_noskip: assert property (p_incr_noskip) else $error("increment skipped");
   property p_incr_echo;
      @(posedge mclk) disable iff (!arst_n)
         incr_zero_wr && s.int_cyc |=> irq_echo == (4'h1 << $past(s.int_line));
   endproperty
   a_incr_echo: assert property (p_incr_echo) else $error("echo missing");
   property p_incr_main;
      @(posedge mclk) disable iff (!arst_n)
         incr_zero_wr && !s.int_cyc |=> s.pc == $past(s.pc) + 16'h0001 && irq_echo == 4'h0;
   endproperty
   a_incr_main: assert property (p_incr_main) else $error("main increment wrong");
   property p_jst_link;
      @(posedge mclk) disable iff (!arst_n) jst_wr |-> mem_we && mem_wdata == s.pc;
   endproperty
   a_jst_link: assert property (p_jst_link) else $error("bad jst link");
   property p_jst_pc;
      @(posedge mclk) disable iff (!arst_n) jst_wr |=> s.pc == $past(mem_addr) + 16'h0001;
   endproperty
   a_jst_pc: assert property (p_jst_pc) else $error("bad jst target");
   property p_jst_dis;
      @(posedge mclk) disable iff (!arst_n) jst_wr && s.int_cyc
         |=> (!int_enabled && irq_ack == 4'h0) ##1 (irq_ack == 4'h0);
   endproperty
   a_jst_dis: assert property (p_jst_dis) else $error("jst left enable");
   property p_auto_keep;
      @(posedge mclk) disable iff (!arst_n) s.st inside {ST_ACNT, ST_AADR, ST_AXFER, ST_AWCNT}
         |=> $stable(s.acc) && $stable(s.idx) && $stable(s.pc) && $stable(s.overflow_indicator);
   endproperty
   a_auto_keep: assert property (p_auto_keep) else $error("auto changed state");
   property p_int_nopc;
      @(posedge mclk) disable iff (!arst_n) s.st == ST_FETCH && mem_ack && s.int_cyc
         && mem_rdata[IIS_OP_HI:IIS_OP_LO] != OP_JMP |=> $stable(s.pc);
   endproperty
   a_int_nopc: assert property (p_int_nopc) else $error("pc moved on fetch");
   property p_recog;
      @(posedge mclk) disable iff (!arst_n) irq_ack != 4'h0 |-> s.st == ST_FETCH && s.int_cyc
         && $past(s.ien) && $onehot(irq_ack) && ((irq_ack - 4'h1) & $past(s.sync2)) == 4'h0;
   endproperty
   a_recog: assert property (p_recog) else $error("bad recognition");
endmodule

// file: bench/iis_mem_model.sv
`timescale 1ns/1ps
module iis_mem_model (
   input wire logic mclk,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [3:0] slow,
   input wire logic io_rd,
   output logic mem_ack,
   output logic [15:0] mem_rdata,
   output logic [15:0] io_rd_data
);
   // ----------------------------------------
   // word store, low 256 words only
   // ----------------------------------------
   logic [15:0] mem [0:255];
   int wait_c = 0;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 16'h0000;
      io_rd_data = 16'h5a5a;
   end
   // answer after slow cycles; an idle bus shows the inverse, never stale data
   always @(negedge mclk) begin
      if (mem_req && wait_c >= int'(slow)) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[mem_addr[7:0]];
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
   // access completes at the acked edge
   always @(posedge mclk) begin
      if (mem_req && mem_ack) begin
         if (mem_we) begin
            mem[mem_addr[7:0]] <= mem_wdata;
         end
         wait_c <= 0;
      end else if (mem_req) begin
         wait_c <= wait_c + 1;
      end
   end
   // peripheral data stays valid until taken, then moves on
   always @(posedge mclk) begin
      if (io_rd) begin
         io_rd_data <= 16'($urandom());
      end
   end
endmodule

// file: bench/tb_iis_seq.sv
`timescale 1ns/1ps
module tb_iis_seq;
   import iis_pkg::*;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] irq_req = 4'h0;
   logic [3:0] slow = 4'h0;
   logic [3:0] irq_ack, irq_echo, echo_or, first;
   logic mem_req, mem_we, mem_ack, io_rd, io_wr, io_byte, overflow_indicator, int_enabled;
   logic [15:0] mem_addr, mem_wdata, mem_rdata, io_rd_data, io_wr_data, pc, acc, idx, w, msk;
   int fail_count = 0;
   int total_checks = 0;
   int n_echo, n_ack, l, b;
   logic [15:0] rd_q[$], wr_q[$], orig[2];
   always #20 mclk = ~mclk;
   iis_seq i_iis_seq (.mclk(mclk), .arst_n(arst_n), .irq_req(irq_req), .irq_ack(irq_ack),
      .irq_echo(irq_echo), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .io_rd_data(io_rd_data), .io_rd(io_rd), .io_wr(io_wr), .io_byte(io_byte),
      .io_wr_data(io_wr_data), .pc(pc), .acc(acc), .idx(idx),
      .overflow_indicator(overflow_indicator), .int_enabled(int_enabled));
   iis_mem_model i_iis_mem_model (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .slow(slow), .io_rd(io_rd),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .io_rd_data(io_rd_data));
   // ----------------------------------------
   // monitors of pulses and peripheral traffic
   // ----------------------------------------
   always @(posedge mclk) begin
      if (arst_n) begin
         n_echo = n_echo + $countones(irq_echo);
         n_ack = n_ack + $countones(irq_ack);
         echo_or = echo_or | irq_echo;
         if (io_wr) wr_q.push_back(io_wr_data);
         if (io_rd) rd_q.push_back(io_rd_data);
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // main program: opening op, 30 adds of one, then a self loop at 0x1f
   task automatic load_base(input logic [15:0] op0);
      for (int a = 0; a < 256; a++) i_iis_mem_model.mem[a] = 16'h0000;
      i_iis_mem_model.mem[0] = op0;
      for (int a = 1; a < 31; a++) i_iis_mem_model.mem[a] = 16'h2050;
      i_iis_mem_model.mem[31] = 16'h401f;
      i_iis_mem_model.mem[80] = 16'h0001;
   endtask
   task automatic rst();
      @(negedge mclk);
      arst_n = 1'b0;
      slow = 4'($urandom_range(0, 2));
      n_echo = 0;
      n_ack = 0;
      echo_or = 4'h0;
      rd_q.delete();
      wr_q.delete();
      repeat (10) @(negedge mclk);
      arst_n = 1'b1;
   endtask
   // raise lines together, drop each as it is acknowledged
   task automatic fire(input logic [3:0] m);
      int t;
      first = 4'h0;
      irq_req = m;
      for (t = 0; t < 3000 && irq_req != 4'h0; t++) begin
         @(negedge mclk);
         if (first == 4'h0) first = irq_ack;
         irq_req = irq_req & ~irq_ack;
      end
      if (t >= 3000) begin
         fail_count++;
         wrap_up();
      end
   endtask
   task automatic wait_pc(input logic [15:0] p, input int settle);
      int t;
      for (t = 0; t < 3000 && pc !== p; t++) @(negedge mclk);
      if (t >= 3000) begin
         fail_count++;
         wrap_up();
      end
      repeat (settle) @(negedge mclk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(16));
      // interrupt counting with relative operand, two lines contending
      l = $urandom_range(0, 2);
      b = $urandom_range(l + 1, 3);
      load_base(16'h0001);
      i_iis_mem_model.mem[32 + l] = 16'h6410;
      i_iis_mem_model.mem[32 + b] = 16'h6410;
      i_iis_mem_model.mem[48 + l] = 16'hffff;
      i_iis_mem_model.mem[48 + b] = 16'h0005;
      rst();
      repeat (4) @(negedge mclk);
      fire(4'(1 << l) | 4'(1 << b));
      chk16({12'h0, first}, 16'(1 << l));
      wait_pc(16'h001f, 20);
      chk16(i_iis_mem_model.mem[48 + l], 16'h0000);
      chk16(i_iis_mem_model.mem[48 + b], 16'h0006);
      chk16({12'h0, echo_or}, 16'(1 << l));
      chk16(16'(n_echo), 16'h0001);
      chk16(16'(n_ack), 16'h0002);
      chk16(acc, 16'h001e);
      $display("test ims_interrupt done");
      // main-program count with interrupts never enabled
      load_base(16'h6040);
      i_iis_mem_model.mem[64] = 16'hffff;
      rst();
      irq_req = 4'hf;
      wait_pc(16'h001f, 20);
      irq_req = 4'h0;
      chk16(acc, 16'h001d);
      chk16(16'(n_echo), 16'h0000);
      chk16(16'(n_ack), 16'h0000);
      $display("test ims_main done");
      // subroutine entry, link, disable, re-enable and indirect return
      l = $urandom_range(0, 3);
      load_base(16'h0001);
      i_iis_mem_model.mem[32 + l] = 16'h5060;
      i_iis_mem_model.mem[97] = 16'h2051;
      i_iis_mem_model.mem[81] = 16'h0100;
      i_iis_mem_model.mem[98] = 16'h0001;
      i_iis_mem_model.mem[99] = 16'h4860;
      rst();
      fire(4'(1 << l));
      // look before the subroutine's own enable has run
      wait_pc(16'h0062, 0);
      chk16({15'h0, int_enabled}, 16'h0000);
      chk16(i_iis_mem_model.mem[96], 16'h0002);
      wait_pc(16'h001f, 20);
      chk16(acc, 16'h011e);
      chk16({15'h0, int_enabled}, 16'h0001);
      $display("test jst_link done");
      // loads, store, overflow, and a disable right after enable with lines held
      load_base(16'h0001);
      i_iis_mem_model.mem[1] = 16'h0002;
      i_iis_mem_model.mem[2] = 16'h7051;
      i_iis_mem_model.mem[3] = 16'h1052;
      i_iis_mem_model.mem[29] = 16'h3053;
      i_iis_mem_model.mem[30] = 16'h2054;
      i_iis_mem_model.mem[81] = 16'($urandom());
      i_iis_mem_model.mem[82] = 16'h7fe0;
      i_iis_mem_model.mem[84] = 16'h0010;
      w = i_iis_mem_model.mem[81];
      rst();
      irq_req = 4'hf;
      wait_pc(16'h001f, 20);
      irq_req = 4'h0;
      chk16(idx, w);
      chk16(i_iis_mem_model.mem[83], 16'h7ff9);
      chk16(acc, 16'h8009);
      chk16({15'h0, overflow_indicator}, 16'h0001);
      chk16({15'h0, int_enabled}, 16'h0000);
      chk16(16'(n_ack), 16'h0000);
      $display("test main_ops done");
      // every auto transfer mode, two units each
      for (int m = 0; m < 4; m++) begin
         l = $urandom_range(0, 3);
         msk = m[1] ? 16'h00ff : 16'hffff;
         load_base(16'h0001);
         i_iis_mem_model.mem[32 + l] = 16'h8070 | 16'(m << 10);
         i_iis_mem_model.mem[112] = 16'hfffe;
         i_iis_mem_model.mem[113] = 16'h0080;
         orig[0] = 16'($urandom());
         orig[1] = 16'($urandom());
         i_iis_mem_model.mem[128] = orig[0];
         i_iis_mem_model.mem[129] = orig[1];
         rst();
         fire(4'(1 << l));
         repeat (3) @(negedge mclk);
         fire(4'(1 << l));
         wait_pc(16'h001f, 20);
         for (int k = 0; k < 2; k++) begin
            if (m[0]) w = (wr_q.size() > k) ? wr_q[k] : 16'hdead;
            else w = (rd_q.size() > k) ? i_iis_mem_model.mem[128 + k] : 16'hdead;
            chk16(w, m[0] ? orig[k] & msk : rd_q[k] & msk);
         end
         chk16(i_iis_mem_model.mem[112], 16'h0000);
         chk16(16'(n_echo), 16'h0001);
         chk16(acc, 16'h001e);
         chk16(idx, 16'h0000);
         chk16({15'h0, overflow_indicator}, 16'h0000);
         chk16({15'h0, io_byte}, {15'h0, m[1]});
      end
      $display("test auto_io done");
      wrap_up();
   end
endmodule
